/* logic/motor_fault_pkg.sv */
// Constants and types of the motor supervisor.
`default_nettype none
package motor_fault_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int WAKE_DELAY_NS  = 1000;
  localparam int SLEEP_ENTRY_NS = 1000;
  localparam int RETRY_NS       = 1000000;
  localparam int WAKE_CYC  = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_CYC = (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_CYC = (RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W     = 20;

  // ****************************************************************
  // Addressing and register layout
  // ****************************************************************
  localparam logic [6:0] ADDR_BASE   = 7'h30;
  localparam logic [7:0] REG_FAULT   = 8'h00;
  localparam logic [7:0] REG_CONFIG0 = 8'h09;
  localparam logic [7:0] REG_CONFIG3 = 8'h0c;
  localparam int FLT_ANY_BIT     = 7;
  localparam int FLT_OC_BIT      = 4;
  localparam int FLT_OV_BIT      = 3;
  localparam int FLT_OT_BIT      = 2;
  localparam int CFG0_OUT_EN_BIT = 7;
  localparam int CFG0_OVP_BIT    = 6;
  localparam int CFG0_CLR_BIT    = 1;
  localparam int CFG3_OC_SEL_BIT = 1;
  localparam int CFG3_OT_SEL_BIT = 0;
  localparam logic OUT_EN_RST = 1'b0;
  localparam logic OVP_EN_RST = 1'b1;
  localparam logic OC_SEL_RST = 1'b0;
  localparam logic OT_SEL_RST = 1'b0;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

  typedef struct packed {
    logic oc;    // Overcurrent trip
    logic hot;   // Junction too hot
    logic cool;  // Junction cooled
    logic ovd;   // Output above supply
    logic hc;    // Sleep brake high current
  } fault_in_t;

  typedef enum logic [2:0] {M_SLEEP, M_STANDBY, M_ACTIVE, M_FAULT} mode_t;
  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_AACK, I_REG, I_RACK, I_DATA, I_DACK, I_TX, I_TXACK, I_TXLOAD
  } i2c_state_t;
endpackage : motor_fault_pkg
`default_nettype wire

/* logic/i2c_target.sv */
// Byte-level I2C target engine.
`default_nettype none
module i2c_target
  import motor_fault_pkg::*;
(
  input  wire logic       clk,       // System clock
  input  wire logic       srst,      // Synchronous reset
  input  wire logic       scl_s,     // Synchronised SCL
  input  wire logic       sda_s,     // Synchronised SDA
  input  wire logic [6:0] dev_addr,  // Own 7-bit address
  input  wire logic [7:0] rd_data,   // Read data for the pointer
  output logic            sda_oe,    // High while pulling SDA low
  output logic            sda_o,     // SDA drive value
  output reg_write_t      wr,        // Register write
  output logic            wr_valid,  // Write pulse
  output logic [7:0]      rd_addr    // Register pointer
);
  i2c_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wd_q, wd_d;
  logic [3:0] cnt_q, cnt_d;
  logic       rw_q, rw_d, oe_q, oe_d, wv_q, wv_d, scl_p_q, sda_p_q;
  logic       rise, fall, start, stop;

  // Bus events
  assign rise  = scl_s & ~scl_p_q;
  assign fall  = ~scl_s & scl_p_q;
  assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ****************************************************************
  // Transaction sequencer
  // ****************************************************************
  always_comb begin
    st_d  = st_q;
    sh_d  = sh_q;
    ptr_d = ptr_q;
    wd_d  = wd_q;
    cnt_d = cnt_q;
    rw_d  = rw_q;
    oe_d  = oe_q;
    wv_d  = 1'b0;
    if (stop) begin
      st_d = I_IDLE;
      oe_d = 1'b0;
    end else if (start) begin
      // Repeated START lands here too, keeping the pointer for a read
      st_d  = I_ADDR;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end else if (rise) begin
      unique case (st_q)
        I_ADDR, I_REG, I_DATA: begin
          sh_d  = {sh_q[6:0], sda_s};
          cnt_d = cnt_q + 4'h1;
        end
        I_TXACK: st_d = sda_s ? I_IDLE : I_TXLOAD;
        default: ;
      endcase
    end else if (fall) begin
      unique case (st_q)
        I_ADDR: if (cnt_q == BYTE_BITS) begin
          // General call: address is never zero
          if (sh_q[7:1] == dev_addr) begin
            oe_d = 1'b1;
            rw_d = sh_q[0];
            st_d = I_AACK;
          end else begin
            st_d = I_IDLE;
          end
        end
        I_REG: if (cnt_q == BYTE_BITS) begin
          oe_d  = 1'b1;
          ptr_d = sh_q;
          st_d  = I_RACK;
        end
        I_DATA: if (cnt_q == BYTE_BITS) begin
          oe_d = 1'b1;
          wd_d = sh_q;
          wv_d = 1'b1;
          st_d = I_DACK;
        end
        I_AACK: begin
          cnt_d = 4'h0;
          if (rw_q) begin
            sh_d  = rd_data;
            oe_d  = ~rd_data[7];
            cnt_d = 4'h1;
            st_d  = I_TX;
          end else begin
            oe_d = 1'b0;
            st_d = I_REG;
          end
        end
        I_RACK, I_DACK: begin
          oe_d  = 1'b0;
          cnt_d = 4'h0;
          st_d  = I_DATA;
        end
        I_TX: if (cnt_q == BYTE_BITS) begin
          oe_d = 1'b0;
          st_d = I_TXACK;
        end else begin
          sh_d  = {sh_q[6:0], 1'b0};
          oe_d  = ~sh_q[6];
          cnt_d = cnt_q + 4'h1;
        end
        I_TXLOAD: begin
          sh_d  = rd_data;
          oe_d  = ~rd_data[7];
          cnt_d = 4'h1;
          st_d  = I_TX;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q    <= I_IDLE;
      sh_q    <= 8'h00;
      ptr_q   <= 8'h00;
      wd_q    <= 8'h00;
      cnt_q   <= 4'h0;
      rw_q    <= 1'b0;
      oe_q    <= 1'b0;
      wv_q    <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      st_q    <= st_d;
      sh_q    <= sh_d;
      ptr_q   <= ptr_d;
      wd_q    <= wd_d;
      cnt_q   <= cnt_d;
      rw_q    <= rw_d;
      oe_q    <= oe_d;
      wv_q    <= wv_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign sda_oe   = oe_q;
  assign sda_o    = 1'b0;  // Open drain: only ever pulls low
  assign wr       = '{addr: ptr_q, data: wd_q};
  assign wr_valid = wv_q;
  assign rd_addr  = ptr_q;
endmodule : i2c_target
`default_nettype wire

/* logic/motor_fault_ctrl.sv */
// Mode, fault and I2C port of the H-bridge driver.
`default_nettype none
// Contract
// - Hi-Z output above supply brakes on both low sides.
// - Brake enable set at power-up; software may clear it.
// - Brake enable survives sleep.
// - Sleep brake: high current turns low sides off.
// - Fault pin released after power-up, low on fault.
// - Active once awake and output enable set.
// - Sleep input low for entry delay: sleep, hi-Z.
// - Wake only after sleep input high past wake delay.
// - Fault disables bridge until recovery.
// - Overcurrent: select 1 retries, else waits for clear.
// - Overtemp: select 0 latches; 1 resumes when cooled.
// - Target only; general call is never acknowledged.
// - Address is base plus 3 x upper plus lower strap.
// - Strap levels sampled once at power-up only.
// - Write: address, register, data, each acked, STOP.
// - Read: pointer write, repeated START, one byte, NACK, STOP.
// - Retry follows controls; persistent trip repeats.
module motor_fault_ctrl
  import motor_fault_pkg::*;
#(
  parameter int RETRY_CYCLES = RETRY_CYC  // Overcurrent retry interval
) (
  input  wire logic       clk,                // System clock
  input  wire logic       srst,               // Power-up reset
  input  wire logic       scl_i,              // SCL pin level
  input  wire logic       sda_i,              // SDA pin level
  output logic            sda_o,              // SDA drive value
  output logic            sda_oe,             // SDA pull-down enable
  input  wire logic       sleep_in_n,         // Sleep request, low active
  input  wire logic       supply_low_lockout, // Supply below lockout
  input  wire logic       overcurrent_trip,   // Overcurrent detected
  input  wire logic       overtemp_trip,      // Junction too hot
  input  wire logic       overtemp_cool,      // Junction below hysteresis
  input  wire logic       overvolt_detect,    // Output above supply margin
  input  wire logic       sleep_high_current, // Brake current too high
  input  wire logic [1:0] addr_strap_upper,   // Upper strap level
  input  wire logic [1:0] addr_strap_lower,   // Lower strap level
  output logic            fault_out_n_o,      // Fault pin drive value
  output logic            fault_out_n_oe,     // Fault pin pull-down enable
  output logic            bridge_enable,      // H-bridge operating
  output logic            low_side_brake,     // Both low sides on
  output logic            sleep_active        // In low-power sleep
);
  // Strap code: low, open, high count 0, 1, 2
  function automatic logic [3:0] strap_code(input logic [1:0] up, input logic [1:0] lo);
    strap_code = {1'b0, up, 1'b0} + {2'b00, up} + {2'b00, lo};
  endfunction : strap_code

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NSYNC = 13;
  logic [NSYNC-1:0] sync1_q, sync2_q;
  logic       scl_s, sda_s, slp_n_s, supply_low_lockout_s;
  logic [1:0] up_s, lo_s;
  fault_in_t  fin;

  always_ff @(posedge clk) begin
    sync1_q <= {scl_i, sda_i, sleep_in_n, supply_low_lockout, overcurrent_trip,
                overtemp_trip, overtemp_cool, overvolt_detect, sleep_high_current,
                addr_strap_upper, addr_strap_lower};
    sync2_q <= sync1_q;
  end
  assign {scl_s, sda_s, slp_n_s, supply_low_lockout_s, fin, up_s, lo_s} = sync2_q;

  // Lockout resets mode, status and registers as power-up does, but not strap capture or the fault pin
  logic hard_rst;
  assign hard_rst = srst | supply_low_lockout_s;

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic       strap_done_q, strap_done_d;
  logic [6:0] dev_addr_q, dev_addr_d;

  // Freeze address after synchroniser settles
  always_comb begin
    strap_cnt_d  = strap_cnt_q;
    strap_done_d = strap_done_q;
    dev_addr_d   = dev_addr_q;
    if (!strap_done_q) begin
      strap_cnt_d = strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'h3) begin
        dev_addr_d   = ADDR_BASE + {3'h0, strap_code(up_s, lo_s)};
        strap_done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      dev_addr_q   <= ADDR_BASE;
    end else begin
      strap_cnt_q  <= strap_cnt_d;
      strap_done_q <= strap_done_d;
      dev_addr_q   <= dev_addr_d;
    end
  end

  // ****************************************************************
  // I2C target and register file
  // ****************************************************************
  mode_t      mode_q, mode_d;
  reg_write_t wr;
  logic       wr_valid, i2c_rst;
  logic [7:0] rd_addr, rd_data;
  logic       out_en_q, out_en_d, ovp_en_q, ovp_en_d, oc_sel_q, oc_sel_d;
  logic       ot_sel_q, ot_sel_d, clr_q, clr_d;
  logic       oc_stat_q, oc_stat_d, ot_stat_q, ot_stat_d, ov_stat_q, ov_stat_d;

  // Sleep also resets the interface
  assign i2c_rst = hard_rst | (mode_q == M_SLEEP);

  i2c_target u_i2c (
    .clk      (clk),
    .srst     (i2c_rst),
    .scl_s    (scl_s),
    .sda_s    (sda_s),
    .dev_addr (dev_addr_q),
    .rd_data  (rd_data),
    .sda_oe   (sda_oe),
    .sda_o    (sda_o),
    .wr       (wr),
    .wr_valid (wr_valid),
    .rd_addr  (rd_addr)
  );

  // Read view; unmapped pointers read zero
  always_comb begin
    rd_data = 8'h00;
    unique case (rd_addr)
      REG_FAULT: begin
        rd_data[FLT_ANY_BIT] = (mode_q == M_FAULT);
        rd_data[FLT_OC_BIT]  = oc_stat_q;
        rd_data[FLT_OV_BIT]  = ov_stat_q;
        rd_data[FLT_OT_BIT]  = ot_stat_q;
      end
      REG_CONFIG0: begin
        rd_data[CFG0_OUT_EN_BIT] = out_en_q;
        rd_data[CFG0_OVP_BIT]    = ovp_en_q;
      end
      REG_CONFIG3: begin
        rd_data[CFG3_OC_SEL_BIT] = oc_sel_q;
        rd_data[CFG3_OT_SEL_BIT] = ot_sel_q;
      end
      default: ;
    endcase
  end

  // Register writes; clear is a pulse
  always_comb begin
    out_en_d = out_en_q;
    ovp_en_d = ovp_en_q;
    oc_sel_d = oc_sel_q;
    ot_sel_d = ot_sel_q;
    clr_d    = 1'b0;
    if (wr_valid && wr.addr == REG_CONFIG0) begin
      out_en_d = wr.data[CFG0_OUT_EN_BIT];
      ovp_en_d = wr.data[CFG0_OVP_BIT];
      clr_d    = wr.data[CFG0_CLR_BIT];
    end else if (wr_valid && wr.addr == REG_CONFIG3) begin
      oc_sel_d = wr.data[CFG3_OC_SEL_BIT];
      ot_sel_d = wr.data[CFG3_OT_SEL_BIT];
    end
  end

  // Brake enable only resets on power-up or lockout, not on sleep
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      ovp_en_q <= OVP_EN_RST;
    end else begin
      ovp_en_q <= ovp_en_d;
    end
    if (i2c_rst) begin
      out_en_q <= OUT_EN_RST;
      oc_sel_q <= OC_SEL_RST;
      ot_sel_q <= OT_SEL_RST;
      clr_q    <= 1'b0;
    end else begin
      out_en_q <= out_en_d;
      oc_sel_q <= oc_sel_d;
      ot_sel_q <= ot_sel_d;
      clr_q    <= clr_d;
    end
  end

  // ****************************************************************
  // Mode sequencer
  // ****************************************************************
  logic [TMR_W-1:0] tmr_q, tmr_d, rty_q, rty_d;
  logic             oc_cause_q, oc_cause_d, ot_cause_q, ot_cause_d;
  logic             oc_ok, ot_ok, hiz, hc_trip_q, hc_trip_d;

  // Per-cause recovery
  assign oc_ok = !oc_cause_q || (oc_sel_q ? (rty_q == TMR_W'(RETRY_CYCLES - 1)) : clr_q);
  assign ot_ok = !ot_cause_q || (!fin.hot && (ot_sel_q ? fin.cool : clr_q));
  assign hiz   = (mode_q != M_ACTIVE);

  always_comb begin
    mode_d     = mode_q;
    tmr_d      = tmr_q;
    rty_d      = rty_q;
    oc_cause_d = oc_cause_q;
    ot_cause_d = ot_cause_q;
    unique case (mode_q)
      M_SLEEP: begin
        oc_cause_d = 1'b0;
        ot_cause_d = 1'b0;
        if (slp_n_s) begin
          tmr_d = tmr_q + TMR_W'(1);
          if (tmr_q == TMR_W'(WAKE_CYC)) begin
            mode_d = M_STANDBY;
            tmr_d  = '0;
          end
        end else begin
          tmr_d = '0;
        end
      end
      M_STANDBY: if (out_en_q) mode_d = M_ACTIVE;
      M_ACTIVE: begin
        if (fin.oc || fin.hot) begin
          mode_d     = M_FAULT;
          oc_cause_d = fin.oc;
          ot_cause_d = fin.hot;
          rty_d      = '0;
        end else if (!out_en_q) begin
          mode_d = M_STANDBY;
        end
      end
      M_FAULT: begin
        rty_d = (oc_cause_q && oc_sel_q) ? rty_q + TMR_W'(1) : '0;
        if (fin.hot) ot_cause_d = 1'b1;
        if (oc_ok && ot_ok && !fin.hot) begin
          // Persisting trip faults again
          mode_d     = out_en_q ? M_ACTIVE : M_STANDBY;
          oc_cause_d = 1'b0;
          ot_cause_d = 1'b0;
        end
      end
    endcase
    // Sleep entry wins
    if (mode_q != M_SLEEP) begin
      if (slp_n_s) begin
        tmr_d = '0;
      end else if (tmr_q == TMR_W'(SLEEP_CYC - 1)) begin
        mode_d = M_SLEEP;
        tmr_d  = '0;
      end else begin
        tmr_d = tmr_q + TMR_W'(1);
      end
    end
  end

  // Sticky overcurrent and overtemp status; set beats clear
  always_comb begin
    oc_stat_d = (oc_stat_q && !clr_q) || (mode_q == M_ACTIVE && fin.oc);
    ot_stat_d = (ot_stat_q && !clr_q) || (mode_q != M_SLEEP && fin.hot);
    ov_stat_d = hiz && fin.ovd;
    hc_trip_d = fin.ovd && (hc_trip_q || (mode_q == M_SLEEP && fin.hc));
  end

  always_ff @(posedge clk) begin
    if (hard_rst) begin
      mode_q     <= M_SLEEP;
      tmr_q      <= '0;
      rty_q      <= '0;
      oc_cause_q <= 1'b0;
      ot_cause_q <= 1'b0;
      oc_stat_q  <= 1'b0;
      ot_stat_q  <= 1'b0;
      ov_stat_q  <= 1'b0;
      hc_trip_q  <= 1'b0;
    end else begin
      mode_q     <= mode_d;
      tmr_q      <= tmr_d;
      rty_q      <= rty_d;
      oc_cause_q <= oc_cause_d;
      ot_cause_q <= ot_cause_d;
      oc_stat_q  <= (mode_q == M_SLEEP) ? 1'b0 : oc_stat_d;
      ot_stat_q  <= (mode_q == M_SLEEP) ? 1'b0 : ot_stat_d;
      ov_stat_q  <= ov_stat_d;
      hc_trip_q  <= hc_trip_d;
    end
  end

  // ****************************************************************
  // Pin outputs
  // ****************************************************************
  logic brake_d, flt_oe_d;

  // Next mode, so brake never overlaps bridge turn-on
  always_comb begin
    brake_d  = (mode_d != M_ACTIVE) && ovp_en_q && fin.ovd && !hc_trip_q
               && !(mode_q == M_SLEEP && fin.hc);
    flt_oe_d = (mode_d == M_FAULT) || supply_low_lockout_s;
  end

  // Only power-up reset here, so lockout can still pull the fault pin
  always_ff @(posedge clk) begin
    if (srst) begin
      fault_out_n_oe <= 1'b0;
      fault_out_n_o  <= 1'b1;
      bridge_enable  <= 1'b0;
      low_side_brake <= 1'b0;
      sleep_active   <= 1'b1;
    end else begin
      fault_out_n_oe <= flt_oe_d;
      fault_out_n_o  <= ~flt_oe_d;
      bridge_enable  <= !hard_rst && (mode_d == M_ACTIVE);
      low_side_brake <= !hard_rst && brake_d;
      sleep_active   <= hard_rst || (mode_d == M_SLEEP);
    end
  end
endmodule : motor_fault_ctrl
`default_nettype wire

/* bench/motor_fault_ctrl_chk.sv */
// Port assertions for the motor supervisor.
`default_nettype none
module motor_fault_ctrl_chk
#(
  parameter int RETRY_CYCLES = 20  // Retry interval
) (
  input wire logic clk,                 // Clock
  input wire logic srst,                // Reset
  input wire logic scl_i,               // SCL level
  input wire logic sda_oe,              // SDA pull
  input wire logic sleep_in_n,          // Sleep request
  input wire logic supply_low_lockout,  // Lockout
  input wire logic overcurrent_trip,    // Overcurrent
  input wire logic overtemp_trip,       // Overtemp
  input wire logic overvolt_detect,     // Overvoltage
  input wire logic sleep_high_current,  // Brake current
  input wire logic fault_out_n_o,       // Fault value
  input wire logic fault_out_n_oe,      // Fault pull
  input wire logic bridge_enable,       // Bridge on
  input wire logic low_side_brake,      // Brake on
  input wire logic sleep_active         // Asleep
);
  // ****************
  // Helper counters
  // ****************
  logic [3:0] age_q = 4'hf;
  logic [3:0] age_d;
  logic [7:0] hi_q  = 8'h00;
  logic [7:0] hi_d;
  logic [7:0] lo_q  = 8'h00;
  logic [7:0] lo_d;
  // Saturating ages, no reset
  always_comb begin
    age_d = age_q + {3'h0, age_q != 4'hf};
    hi_d  = sleep_in_n ? hi_q + {7'h0, hi_q != 8'hff} : 8'h00;
    lo_d  = sleep_in_n ? 8'h00 : lo_q + {7'h0, lo_q != 8'hff};
    if (overcurrent_trip || overtemp_trip || supply_low_lockout) begin
      age_d = 4'h0;
    end
  end
  // Register the counters
  always_ff @(posedge clk) begin
    age_q <= age_d;
    hi_q  <= hi_d;
    lo_q  <= lo_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Bridge off, pin pulled
  sequence s_off;
    !bridge_enable && fault_out_n_oe;
  endsequence
  property p_pin_level; fault_out_n_o == !fault_out_n_oe; endproperty
  a_pin_level: assert property (p_pin_level) else $error("fault value not inverse");
  property p_oc_trip; bridge_enable && overcurrent_trip |-> ##[1:4] s_off; endproperty
  a_oc_trip: assert property (p_oc_trip) else $error("overcurrent kept bridge on");
  property p_ot_trip; bridge_enable && overtemp_trip |-> ##[1:4] s_off; endproperty
  a_ot_trip: assert property (p_ot_trip) else $error("overtemp kept bridge on");
  property p_cause; $rose(fault_out_n_oe) |-> age_q <= 4'd4; endproperty
  a_cause: assert property (p_cause) else $error("fault pin without cause");
  property p_brake_src;
    $rose(low_side_brake) |-> $past(overvolt_detect) || $past(overvolt_detect, 2)
      || $past(overvolt_detect, 3) || $past(overvolt_detect, 4);
  endproperty
  a_brake_src: assert property (p_brake_src) else $error("brake without overvoltage");
  property p_brake_excl; low_side_brake |-> !bridge_enable; endproperty
  a_brake_excl: assert property (p_brake_excl) else $error("brake while driving");
  property p_brake_hc; (sleep_active && sleep_high_current)[*5] |=> !low_side_brake; endproperty
  a_brake_hc: assert property (p_brake_hc) else $error("brake kept on high current");
  property p_sleep; lo_q == 8'd110 |-> sleep_active && !bridge_enable; endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep after entry delay");
  property p_wake; $fell(sleep_active) |-> hi_q > 8'd100; endproperty
  a_wake: assert property (p_wake) else $error("woke before wake delay");
  property p_ack; $rose(sda_oe) |-> !scl_i; endproperty
  a_ack: assert property (p_ack) else $error("SDA pulled while SCL high");
endmodule : motor_fault_ctrl_chk
`default_nettype wire

/* bench/i2c_host_model.sv */
// Behavioural I2C controller.
`default_nettype none
module i2c_host_model (
  output logic     scl,      // Bus clock, idle high
  output logic     sda_drv,  // SDA drive, 0 pulls low
  input wire logic sda_bus   // Resolved SDA level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // One 160 ns bit
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    #40 scl = 1'b1;
    #40 r = sda_bus;
    #40 scl = 1'b0;
    #40;
  endtask : bit_io
  // START, or repeated START from SCL low
  task automatic start;
    sda_drv = 1'b1;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b0;
    #40;
  endtask : start
  // STOP, then the bus is left idle
  task automatic stop;
    sda_drv = 1'b0;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #80;
  endtask : stop
  // Byte out MSB first; ack when pulled low
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask : put
  // Write: address, register, data, then STOP
  task automatic wr(input logic [6:0] a, input logic [7:0] ra, d, output logic [2:0] k);
    start;
    put({a, 1'b0}, k[2]);
    put(ra, k[1]);
    put(d, k[0]);
    stop;
  endtask : wr
  // Read: pointer, repeated START, byte, NACK
  task automatic rd(input logic [6:0] a, input logic [7:0] ra, output logic [7:0] d,
                    output logic [2:0] k);
    logic r;
    start;
    put({a, 1'b0}, k[2]);
    put(ra, k[1]);
    start;
    put({a, 1'b1}, k[0]);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
    stop;
  endtask : rd
endmodule : i2c_host_model
`default_nettype wire

/* bench/motor_fault_ctrl_bench.sv */
// Bench for the motor supervisor.
`default_nettype none
module motor_fault_ctrl_bench
  import motor_fault_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RETRY = 20;
  localparam int LIMIT = 40000;
  typedef struct packed {logic [1:0] u; logic [1:0] l; logic [6:0] a;} strap_row_t;
  // Straps and expected address
  strap_row_t rows [9] = '{'{2'h0, 2'h0, 7'h30}, '{2'h0, 2'h1, 7'h31}, '{2'h0, 2'h2, 7'h32},
                           '{2'h1, 2'h0, 7'h33}, '{2'h1, 2'h1, 7'h34}, '{2'h1, 2'h2, 7'h35},
                           '{2'h2, 2'h0, 7'h36}, '{2'h2, 2'h1, 7'h37}, '{2'h2, 2'h2, 7'h38}};
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       sleep_n = 1'b1;
  logic       lockout = 1'b0;
  fault_in_t  fin = 5'b00100;
  logic [1:0] up = 2'h0;
  logic [1:0] lo = 2'h0;
  logic       scl, sda_drv, sda_o, sda_oe, pin_o, pin_oe, bridge, brake, asleep;
  int         bad_count = 0;
  int         tests_run = 0;
  // Pull-ups on SDA and the fault pin
  wire        sda = sda_drv & !(sda_oe & !sda_o);
  wire        fpin = pin_oe ? pin_o : 1'b1;
  wire  [3:0] st = {bridge, fpin, brake, asleep};
  // 100 MHz clock
  always #5 clk = ~clk;
  motor_fault_ctrl #(.RETRY_CYCLES(RETRY)) u_dut (
    .clk, .srst, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .sleep_in_n(sleep_n),
    .supply_low_lockout(lockout), .overcurrent_trip(fin.oc), .overtemp_trip(fin.hot),
    .overtemp_cool(fin.cool), .overvolt_detect(fin.ovd), .sleep_high_current(fin.hc),
    .addr_strap_upper(up), .addr_strap_lower(lo), .fault_out_n_o(pin_o),
    .fault_out_n_oe(pin_oe), .bridge_enable(bridge), .low_side_brake(brake),
    .sleep_active(asleep));
  i2c_host_model u_host (.scl, .sda_drv, .sda_bus(sda));
  // ****************
  // Shared tasks
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic check(input logic [7:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  // Sample mid-cycle
  task automatic state(input logic [3:0] e);
    @(negedge clk);
    check({4'h0, st}, {4'h0, e}, "outputs");
    @(posedge clk);
  endtask : state
  task automatic wr(input logic [6:0] a, input logic [7:0] r, d, input logic [2:0] ek);
    logic [2:0] k;
    u_host.wr(a, r, d, k);
    check({5'h0, k}, {5'h0, ek}, "write acks");
    cyc(4);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] r, m, e);
    logic [7:0] d;
    logic [2:0] k;
    u_host.rd(a, r, d, k);
    check({5'h0, k}, 8'h07, "read acks");
    check(d & m, e, "read data");
    cyc(1);
  endtask : rd
  // Straps latch at power-up only
  task automatic power_up(input logic [1:0] u, l);
    srst <= 1'b1;
    up <= u;
    lo <= l;
    cyc(16);
    srst <= 1'b0;
    cyc(200);
  endtask : power_up
  task automatic summarize;
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  // Watchdog
  initial begin
    repeat (LIMIT) @(posedge clk);
    bad_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    summarize();
  end
  // Strap table, then hand cases
  initial begin
    @(posedge clk);
    foreach (rows[i]) begin
      power_up(rows[i].u, rows[i].l);
      state(4'h4);
      wr(rows[i].a, REG_CONFIG0, 8'hc0, 3'h7);
      state(4'hc);
      $display("test strap row %0d done", i);
    end
    up <= 2'h0;
    lo <= 2'h0;
    wr(7'h30, REG_CONFIG0, 8'h00, 3'h0);
    wr(7'h00, REG_CONFIG0, 8'h00, 3'h0);
    wr(7'h38, 8'h05, 8'h00, 3'h7);
    state(4'hc);
    rd(7'h38, REG_CONFIG0, 8'hc0, 8'hc0);
    $display("test addressing done");
    fin.oc <= 1'b1;
    cyc(3);
    fin.oc <= 1'b0;
    cyc(3 + 2 * RETRY);
    state(4'h0);
    rd(7'h38, REG_FAULT, 8'h90, 8'h90);
    wr(7'h38, REG_CONFIG0, 8'hc2, 3'h7);
    state(4'hc);
    wr(7'h38, REG_CONFIG3, 8'h02, 3'h7);
    fin.oc <= 1'b1;
    cyc(5);
    state(4'h0);
    cyc(3 * RETRY);
    fin.oc <= 1'b0;
    cyc(2 * RETRY);
    state(4'hc);
    $display("test overcurrent done");
    for (int s = 0; s < 2; s++) begin
      wr(7'h38, REG_CONFIG3, {7'h0, s[0]}, 3'h7);
      fin.hot <= 1'b1;
      fin.cool <= 1'b0;
      cyc(10);
      fin.hot <= 1'b0;
      cyc(10);
      state(4'h0);
      fin.cool <= 1'b1;
      cyc(10);
      state(s ? 4'hc : 4'h0);
      if (s == 0) begin
        wr(7'h38, REG_CONFIG0, 8'hc2, 3'h7);
      end
      state(4'hc);
      rd(7'h38, REG_FAULT, 8'h84, s ? 8'h04 : 8'h00);
    end
    $display("test overtemp done");
    wr(7'h38, REG_CONFIG0, 8'h40, 3'h7);
    fin.ovd <= 1'b1;
    cyc(6);
    state(4'h6);
    rd(7'h38, REG_FAULT, 8'h88, 8'h08);
    wr(7'h38, REG_CONFIG0, 8'h00, 3'h7);
    state(4'h4);
    $display("test overvoltage done");
    sleep_n <= 1'b0;
    cyc(50);
    state(4'h4);
    cyc(60);
    state(4'h5);
    lockout <= 1'b1;
    fin.ovd <= 1'b0;
    cyc(6);
    state(4'h1);
    lockout <= 1'b0;
    fin.ovd <= 1'b1;
    cyc(6);
    state(4'h7);
    fin.hc <= 1'b1;
    cyc(8);
    state(4'h5);
    $display("test sleep done");
    summarize();
  end
endmodule : motor_fault_ctrl_bench
bind motor_fault_ctrl motor_fault_ctrl_chk #(.RETRY_CYCLES(RETRY_CYCLES)) u_chk (
  .clk, .srst, .scl_i, .sda_oe, .sleep_in_n, .supply_low_lockout, .overcurrent_trip,
  .overtemp_trip, .overvolt_detect, .sleep_high_current, .fault_out_n_o, .fault_out_n_oe,
  .bridge_enable, .low_side_brake, .sleep_active);
`default_nettype wire
